// file: src/mrs_consts.vh
// constants for the receive statistics counter bank
`ifndef MRS_CONSTS_VH
`define MRS_CONSTS_VH
// register word offsets (byte addresses)
`define MRS_OFS_GOOD       8'h00
`define MRS_OFS_BCAST      8'h04
`define MRS_OFS_MCAST      8'h08
`define MRS_OFS_PAUSE      8'h0C
`define MRS_OFS_CRC        8'h10
`define MRS_OFS_ALIGN      8'h14
`define MRS_OFS_OVERSIZE   8'h18
`define MRS_OFS_JABBER     8'h1C
`define MRS_OFS_UNDERSIZE  8'h20
`define MRS_OFS_FRAGMENT   8'h24
`define MRS_OFS_CTRL       8'h28
`define MRS_OFS_STATUS     8'h2C
`define MRS_OFS_MAXLEN     8'h30
`define MRS_NUM_CNT        10
// control register fields
`define MRS_CTRL_MIEN_BIT  0
`define MRS_CTRL_PAUSE_BIT 1
`define MRS_CTRL_IRQEN_BIT 2
// reset values, half-scale bit and frame match constants
`define MRS_CNT_RST        32'h0000_0000
`define MRS_MAXLEN_RST     16'h05EE
`define MRS_HALF_SCALE_BIT 31
`define MRS_MIN_FRAME_LEN  16'h0040
`define MRS_PAUSE_TYPE     16'h8808
`define MRS_PAUSE_OPCODE   16'h0001
// clear delay after reset
`define MRS_CLR_DELAY      6'h26
`endif

// file: src/mrs_rx_stats.v
// receive statistics counter bank with register port
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "mrs_consts.vh"

//
// Contract
// RQ1: counters cleared 38 clocks after reset
// RQ2: media enable set: writes decrement, saturating
// RQ3: media enable clear: writes store directly
// RQ4: software writes full 32-bit words only
// RQ5: irq pending while any counter at half-scale
// RQ6: irq drops once no counter at half-scale
// RQ7: 32-bit counters wrap past all ones
// RQ8: count good frames 64 to max
// RQ9: count good broadcast frames
// RQ10: count good non-broadcast multicast frames
// RQ11: count valid pause frames when enabled
// RQ12: count matched in-range CRC errors
// RQ13: count matched in-range alignment errors
// RQ14: receive error input marks code error
// RQ15: count oversized error-free matched frames
// RQ16: count oversized errored matched frames as jabber
// RQ17: count undersized error-free matched data frames
// RQ18: count short errored data frames as fragments
// RQ19: overruns never affect these counts
// RQ20: write applied first, then increment
module mrs_rx_stats
(
  input  wire        ref_clk_i,
  input  wire        srst_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        frame_done_i,
  input  wire [15:0] frame_len_i,
  input  wire        addr_match_i,
  input  wire        promisc_i,
  input  wire        is_control_i,
  input  wire        is_broadcast_i,
  input  wire        is_multicast_i,
  input  wire [15:0] len_type_i,
  input  wire [15:0] opcode_i,
  input  wire        odd_nibbles_i,
  input  wire        fcs_fail_i,
  input  wire        collision_frame_i,
  input  wire        overrun_i,
  input  wire        rx_error_input_i,
  output wire        stats_irq_pending_o
);

  // ************************************************************
  // pin synchroniser for the receive error input
  // ************************************************************
  reg rxer_s1_q;
  reg rxer_s2_q;
  reg code_err_q;
  always @(posedge ref_clk_i)
  begin
    rxer_s1_q <= rx_error_input_i;
    rxer_s2_q <= rxer_s1_q;
  end

  // latch a code error anywhere in the frame, cleared at frame end
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
      code_err_q <= 1'b0;
    else if (frame_done_i)
      code_err_q <= 1'b0;
    else if (rxer_s2_q)
      code_err_q <= 1'b1; // [RQ14]
  end

  // ************************************************************
  // control registers
  // ************************************************************
  reg [2:0]  ctrl_q;
  reg [15:0] max_rx_frame_length_q;
  reg [5:0]  clr_cnt_q;
  reg        clr_busy_q;
  wire       media_interface_enable = ctrl_q[`MRS_CTRL_MIEN_BIT];
  wire       pause_handling_enable  = ctrl_q[`MRS_CTRL_PAUSE_BIT];
  wire       irq_enable             = ctrl_q[`MRS_CTRL_IRQEN_BIT];

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q                <= 3'h0;
      max_rx_frame_length_q <= `MRS_MAXLEN_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == `MRS_OFS_CTRL)
        ctrl_q <= wdata_i[2:0];
      if (addr_i == `MRS_OFS_MAXLEN)
        max_rx_frame_length_q <= wdata_i[15:0];
    end
  end

  // delayed clear: counts 38 clocks after reset release
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      clr_cnt_q  <= 6'h00;
      clr_busy_q <= 1'b1;
    end
    else if (clr_busy_q)
    begin
      clr_cnt_q <= clr_cnt_q + 6'h01;
      if (clr_cnt_q == `MRS_CLR_DELAY - 6'h01)
        clr_busy_q <= 1'b0;
    end
  end
  wire clr_now = clr_busy_q && (clr_cnt_q == `MRS_CLR_DELAY - 6'h01); // [RQ1]

  // ************************************************************
  // frame classification
  // ************************************************************
  // overrun_i is deliberately unused by every term below [RQ19]
  wire        matched   = addr_match_i | promisc_i;
  wire        code_err  = code_err_q | rxer_s2_q;
  wire        align_err = odd_nibbles_i & fcs_fail_i;                   // [RQ13]
  wire        crc_err   = ~odd_nibbles_i & fcs_fail_i;                  // [RQ12]
  wire        any_err   = crc_err | align_err | code_err;
  wire        too_short = frame_len_i < `MRS_MIN_FRAME_LEN;
  wire        too_long  = frame_len_i > max_rx_frame_length_q;
  wire        in_range  = ~too_short & ~too_long;
  wire        good      = matched & in_range & ~any_err;                // [RQ8]
  wire [9:0]  inc;

  assign inc[0] = frame_done_i & good;                                  // [RQ8]
  assign inc[1] = frame_done_i & good & is_broadcast_i;                 // [RQ9]
  assign inc[2] = frame_done_i & good & is_multicast_i & ~is_broadcast_i; // [RQ10]
  assign inc[3] = frame_done_i & good & pause_handling_enable
                  & (len_type_i == `MRS_PAUSE_TYPE)
                  & (opcode_i == `MRS_PAUSE_OPCODE);                    // [RQ11]
  assign inc[4] = frame_done_i & matched & in_range & crc_err
                  & ~code_err;                                          // [RQ12]
  assign inc[5] = frame_done_i & matched & in_range
                  & (align_err | code_err);                             // [RQ13] [RQ14]
  assign inc[6] = frame_done_i & matched & too_long & ~any_err;         // [RQ15]
  assign inc[7] = frame_done_i & matched & too_long & any_err;          // [RQ16]
  assign inc[8] = frame_done_i & matched & ~is_control_i & too_short
                  & ~any_err;                                           // [RQ17]
  assign inc[9] = frame_done_i & ~is_control_i & too_short & any_err
                  & ~collision_frame_i;                                 // [RQ18]

  // ************************************************************
  // counter bank
  // ************************************************************
  reg  [31:0] cnt_q [0:`MRS_NUM_CNT-1];
  wire [9:0]  half;
  genvar gi;
  generate
    for (gi = 0; gi < `MRS_NUM_CNT; gi = gi + 1)
    begin : g_cnt
      wire        hit  = wr_i && (addr_i == gi * 4);
      // software must write whole words, so no byte lanes exist [RQ4]
      wire [31:0] wval = media_interface_enable ?
                         ((wdata_i > cnt_q[gi]) ? `MRS_CNT_RST
                                                : cnt_q[gi] - wdata_i) // [RQ2]
                         : wdata_i;                                    // [RQ3]
      wire [31:0] base = hit ? wval : cnt_q[gi];                       // [RQ20]
      always @(posedge ref_clk_i)
      begin
        if (srst_i || clr_now)
          cnt_q[gi] <= `MRS_CNT_RST;                                   // [RQ1]
        else
          cnt_q[gi] <= base + {31'h0, inc[gi]};                        // [RQ7] [RQ20]
      end
      assign half[gi] = cnt_q[gi][`MRS_HALF_SCALE_BIT];
    end
  endgenerate

  // level output: falls as soon as the last counter drops below half
  assign stats_irq_pending_o = irq_enable & (|half);                  // [RQ5] [RQ6]

  // ************************************************************
  // read port
  // ************************************************************
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      if (addr_i < `MRS_OFS_CTRL && addr_i[1:0] == 2'b00)
        rdata_o <= cnt_q[addr_i[5:2]];
      else if (addr_i == `MRS_OFS_CTRL)
        rdata_o <= {29'h0, ctrl_q};
      else if (addr_i == `MRS_OFS_STATUS)
        rdata_o <= {22'h0, half};
      else if (addr_i == `MRS_OFS_MAXLEN)
        rdata_o <= {16'h0000, max_rx_frame_length_q};
      else
        rdata_o <= 32'h0000_0000;
    end
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule // mrs_rx_stats

// file: tb/mrs_rx_stats_chk.sv
// checker for the receive statistics counter bank
`timescale 1ns/1ns
module mrs_rx_stats_chk
(
  input wire        ref_clk_i,
  input wire        srst_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        frame_done_i,
  input wire        stats_irq_pending_o
);
  reg [5:0] cnt_q;
  reg       irqen_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // edges since release; held at the top so it never re-enters the clear window
  always @(posedge ref_clk_i)
  begin
    cnt_q <= srst_i ? 6'h00 : cnt_q + {5'h00, cnt_q != 6'h3F};
    irqen_q <= srst_i ? 1'b0 : (wr_i && addr_i == 8'h28) ? wdata_i[2] : irqen_q;
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not idle");
  a_read_range: assert property (rd_i && (addr_i > 8'h30 || addr_i[1:0] != 2'h0)
    |=> rdata_o == 32'h0000_0000) else $error("bad address read");
  a_clear_delay: assert property (rd_i && cnt_q == 6'h26 && addr_i < 8'h28
    && !$past(frame_done_i) |=> rdata_o == 32'h0000_0000) else $error("not cleared");
  a_reset_quiet: assert property ($fell(srst_i) |-> !stats_irq_pending_o [*8])
    else $error("irq after reset");
  a_irq_gated: assert property (!irqen_q |-> !stats_irq_pending_o)
    else $error("irq while disabled");
  a_status_set: assert property (rd_i && addr_i == 8'h2C && stats_irq_pending_o
    |=> rdata_o != 32'h0000_0000) else $error("status empty");
  a_status_clear: assert property (rd_i && addr_i == 8'h2C && irqen_q
    && !stats_irq_pending_o |=> rdata_o == 32'h0000_0000) else $error("status stuck");
  a_irq_cause: assert property ($changed(stats_irq_pending_o)
    |-> $past(wr_i) || $past(frame_done_i) || cnt_q == 6'h26) else $error("irq moved");
endmodule // mrs_rx_stats_chk

// file: tb/mrs_rx_stats_test.sv
// self-checking bench for the receive statistics counter bank
`timescale 1ns/1ns
module mrs_rx_stats_test;
  reg          ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  reg          frame_done_i = 1'b0, rx_error_input_i = 1'b0;
  reg  [7:0]   addr_i = 8'h00;
  reg  [8:0]   flags = 9'h000;
  reg  [15:0]  frame_len_i = 16'h0000;
  reg  [31:0]  wdata_i = 32'h0000_0000;
  reg  [31:0]  exp_q [0:9] = '{default: 32'h0000_0000};
  wire [31:0]  rdata_o;
  wire         stats_irq_pending_o;
  integer      errors = 0, checks = 0, i, j;
  // length, {match,promisc,ctl,bcast,mcast,odd,fcs,coll,overrun}, counters hit
  reg  [454:0] tbl = {{16'h0040, 9'h100, 10'h001}, {16'h05EE, 9'h120, 10'h003},
    {16'h0064, 9'h110, 10'h005}, {16'h0040, 9'h140, 10'h009}, {16'h0040, 9'h104, 10'h010},
    {16'h0040, 9'h10C, 10'h020}, {16'h05EF, 9'h100, 10'h040}, {16'h05EF, 9'h104, 10'h080},
    {16'h003F, 9'h100, 10'h100}, {16'h003F, 9'h004, 10'h200}, {16'h003F, 9'h006, 10'h000},
    {16'h003F, 9'h140, 10'h000}, {16'h0064, 9'h081, 10'h001}};
  always #50 ref_clk_i = ~ref_clk_i;
  mrs_rx_stats mrs_rx_stats_inst
  (
    .ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .frame_done_i, .frame_len_i,
    .addr_match_i(flags[8]), .promisc_i(flags[7]), .is_control_i(flags[6]),
    .is_broadcast_i(flags[5]), .is_multicast_i(flags[4]),
    .len_type_i(flags[6] ? 16'h8808 : 16'h0800),
    .opcode_i(16'h0001), .odd_nibbles_i(flags[3]), .fcs_fail_i(flags[2]),
    .collision_frame_i(flags[1]), .overrun_i(flags[0]), .rx_error_input_i, .stats_irq_pending_o
  );
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // frame_done stays high, so consecutive calls give back-to-back frames
  task frm(input [15:0] l, input [8:0] f);
    @(posedge ref_clk_i);
    frame_done_i <= 1'b1;
    frame_len_i <= l;
    flags <= f;
  endtask
  task idle;
    @(posedge ref_clk_i);
    frame_done_i <= 1'b0;
    wr_i <= 1'b0;
  endtask
  task t_clear;
    wr(8'h00, 32'h0000_0005);
    repeat (35) @(posedge ref_clk_i);
    rd(8'h00, 32'h0000_0000);
  endtask
  task t_frames;
    wr(8'h28, 32'h0000_0006);
    for (i = 0; i < 13; i = i + 1)
    begin
      frm(tbl[i*35+19 +: 16], tbl[i*35+10 +: 9]);
      for (j = 0; j < 10; j = j + 1)
        exp_q[j] = exp_q[j] + tbl[i*35+j];
    end
    idle;
    rx_error_input_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rx_error_input_i <= 1'b0;
    // let the synchroniser drain so no stale error leaks past this frame
    repeat (3) @(posedge ref_clk_i);
    frm(16'h0064, 9'h100);
    exp_q[5] = exp_q[5] + 32'h0000_0001;
    idle;
    for (j = 0; j < 10; j = j + 1)
      rd(8'(j*4), exp_q[j]);
  endtask
  task t_write;
    wr(8'h00, 32'hFFFF_FFFF);
    frm(16'h0040, 9'h100);
    idle;
    rd(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h7FFF_FFFF);
    frm(16'h0040, 9'h100);
    idle;
    rd(8'h2C, 32'h0000_0001);
    chk({31'h0, stats_irq_pending_o}, 32'h0000_0001);
    wr(8'h28, 32'h0000_0007);
    wr(8'h00, 32'h0000_0010);
    rd(8'h00, 32'h7FFF_FFF0);
    chk({31'h0, stats_irq_pending_o}, 32'h0000_0000);
    frm(16'h0040, 9'h100);
    wr_i <= 1'b1;
    wdata_i <= 32'hFFFF_FFFF;
    idle;
    rd(8'h00, 32'h0000_0001);
    rd(8'h2C, 32'h0000_0000);
    rd(8'h34, 32'h0000_0000);
  endtask
  task results;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_clear;
    t_frames;
    t_write;
    results;
  end
  // the sequence needs about 130 cycles; the margin absorbs any stall
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    errors = errors + 1;
    results;
  end
endmodule // mrs_rx_stats_test
bind mrs_rx_stats mrs_rx_stats_chk mrs_rx_stats_chk_inst
(
  .ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .frame_done_i, .stats_irq_pending_o
);
